// ---- verilog/acp_defines.vh ----
// Constants for the converter configuration port: timing, fields, decodes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ACP_DEFINES_VH
`define ACP_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ACP_CLK_NS 50
`define ACP_HW_RESET_MIN_NS 10
// Least time, rounded up, never below one cycle
`define ACP_HW_RESET_MIN_CYC \
	((((`ACP_HW_RESET_MIN_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS) < 1) ? 1 : \
	((`ACP_HW_RESET_MIN_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS))
`define ACP_STRAP_HOLD_NS 1000
`define ACP_STRAP_HOLD_CYC \
	((`ACP_STRAP_HOLD_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_SCLK_MAX_HZ 20000000

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define ACP_FRAME_BITS 16
`define ACP_ADDR_LAST_BIT 4'h7
`define ACP_FRAME_LAST_BIT 4'hf
`define ACP_REG_DEFAULT 8'h00

// ----------------------------------------------------------------------
// Control register at address zero
// ----------------------------------------------------------------------
`define ACP_CTRL_ADDR 8'h00
`define ACP_CTRL_READOUT_BIT 0
`define ACP_CTRL_SWRESET_BIT 1

// ----------------------------------------------------------------------
// Strap decodes
// ----------------------------------------------------------------------
`define ACP_SEN_LVL_GND 2'h0
`define ACP_SEN_LVL_3_8 2'h1
`define ACP_SEN_LVL_5_8 2'h2
`define ACP_SEN_LVL_FULL 2'h3
`define ACP_PWR_NORMAL 3'h0
`define ACP_PWR_GLOBAL_PD 3'h4
`define ACP_PWR_A_STANDBY 3'h5
`define ACP_PWR_MUX 3'h7

`endif

// ---- verilog/acp_regfile.v ----
// Register storage of the configuration port: one write, one read port.
// Assumes a single clock; read data appear one cycle after rd_en.
`timescale 1ns/1ps

module acp_regfile #(
	parameter AW = 8,
	parameter DW = 8
) (
	input wire clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data_reg
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_reg <= mem[rd_addr];
		end
	end

endmodule // acp_regfile

// ---- verilog/acp_config_port.v ----
// Configuration front end: strap decode and three-wire serial register port.
// Assumes pins arrive asynchronously; sclk must stay well below clk / 4.
//
// Contract
// [RULE_01] Strap mode: serial clock pin low disables, high enables low speed.
// [RULE_02] Strap mode: four enable-pin levels select data format and interface.
// [RULE_03] Power straps: 000 normal, 100 power-down, 101 A standby.
// [RULE_04] Power straps all high multiplex both channels onto channel B bus.
// [RULE_05] Bits shift only while serial enable is low.
// [RULE_06] Serial data sampled on each falling serial clock edge.
// [RULE_07] Every sixteenth falling edge commits the word to its register.
// [RULE_08] A trailing partial word is dropped without any write.
// [RULE_09] Several frames may follow within one enable-low period.
// [RULE_10] First byte is the address, second byte the data.
// [RULE_11] Serial clock from a few hertz up to 20 MHz, any duty; the code samples it at clk (50 ns), so sclk must stay well below clk / 4.
// [RULE_12] Reset pin pulse longer than 10 ns restores all defaults.
// [RULE_13] Software reset bit restores defaults and clears itself.
// [RULE_14] Controller initialises registers after power-up before use.
// [RULE_15] Readback enable blocks further register writes.
// [RULE_16] Readback frame returns addressed register data on readback pin.
// [RULE_17] Controller captures readback bits on falling serial clock.
// [RULE_18] Controller writes readback enable to zero to resume writes.
// [RULE_19] Readback pin is released while readback enable is zero.
// [RULE_20] Readback works in both CMOS and LVDS output modes; out_lvds is high only in strap mode, where frames and readout are off.
// [RULE_21] Reset pin held high selects strap mode, low selects serial.
// [RULE_22] Address zero: bit 0 readback enable, bit 1 software reset.
// [RULE_23] Frames shift most significant bit first.
// [RULE_24] Register byte driven during final eight clock periods.
`timescale 1ns/1ps
`include "acp_defines.vh"

module acp_config_port #(
	parameter STRAP_HOLD_CYC = `ACP_STRAP_HOLD_CYC,
	parameter HW_RESET_MIN_CYC = `ACP_HW_RESET_MIN_CYC
) (
	input wire clk,
	input wire rstn,
	input wire hw_reset_pin,
	input wire serial_clk,
	input wire serial_select_n,
	input wire [1:0] serial_select_level,
	input wire serial_data_in,
	input wire power_strap_1,
	input wire power_strap_2,
	input wire power_strap_3,
	output reg serial_readback_out,
	output reg serial_readback_oe,
	output reg strap_mode,
	output reg low_speed_mode,
	output reg fmt_offset_binary,
	output reg out_lvds,
	output reg pd_global,
	output reg cha_standby,
	output reg mux_to_channel_b_output_bus,
	output reg readout_enabled,
	output reg reg_clear_busy,
	output reg cfg_wr_strobe,
	output reg [7:0] cfg_wr_addr,
	output reg [7:0] cfg_wr_data
);

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	// Returns {offset_binary, lvds}
	function [1:0] sen_decode;
		input [1:0] lvl;
		begin
			case (lvl)
			`ACP_SEN_LVL_GND: sen_decode = 2'h0;
			`ACP_SEN_LVL_3_8: sen_decode = 2'h2;
			`ACP_SEN_LVL_5_8: sen_decode = 2'h3;
			`ACP_SEN_LVL_FULL: sen_decode = 2'h1;
			default: sen_decode = 2'h0;
			endcase
		end
	endfunction

	// Returns {global_pd, a_standby, mux}; unavailable codes act as normal
	function [2:0] pwr_decode;
		input [2:0] code;
		begin
			case (code)
			`ACP_PWR_GLOBAL_PD: pwr_decode = 3'h4;
			`ACP_PWR_A_STANDBY: pwr_decode = 3'h2;
			`ACP_PWR_MUX: pwr_decode = 3'h1;
			default: pwr_decode = 3'h0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	localparam NSYNC = 9;
	wire [NSYNC-1:0] pin_raw;
	reg [NSYNC-1:0] pin_meta_reg;
	reg [NSYNC-1:0] pin_sync_reg;
	assign pin_raw = {serial_select_level, power_strap_3, power_strap_2,
		power_strap_1, serial_data_in, serial_select_n, serial_clk,
		hw_reset_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (!rstn) begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	wire rst_pin_s = pin_sync_reg[0];
	wire sclk_s = pin_sync_reg[1];
	wire sen_n_s = pin_sync_reg[2];
	wire serial_data_in_s = pin_sync_reg[3];
	wire [2:0] pwr_s = {pin_sync_reg[4], pin_sync_reg[5], pin_sync_reg[6]};
	wire [1:0] sen_lvl_s = pin_sync_reg[8:7];

	reg sclk_d_reg;
	always @(posedge clk) begin
		if (!rstn) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end
	// Sampling at clk sets the usable serial clock ceiling
	wire sclk_fall = sclk_d_reg & ~sclk_s; // RULE_06 RULE_11

	// ------------------------------------------------------------------
	// Reset pin: pulse restores defaults, long hold selects straps
	// ------------------------------------------------------------------
	reg [15:0] rst_high_cnt_reg;
	reg hw_clear_req_reg;
	always @(posedge clk) begin
		if (!rstn) begin
			rst_high_cnt_reg <= 16'h0000;
			hw_clear_req_reg <= 1'b0;
			strap_mode <= 1'b0;
		end else begin
			hw_clear_req_reg <= 1'b0;
			if (!rst_pin_s) begin
				rst_high_cnt_reg <= 16'h0000;
				strap_mode <= 1'b0; // RULE_21
			end else begin
				if (rst_high_cnt_reg != 16'hffff) begin
					rst_high_cnt_reg <= rst_high_cnt_reg + 16'h0001;
				end
				if (rst_high_cnt_reg == HW_RESET_MIN_CYC[15:0] - 16'h0001) begin
					hw_clear_req_reg <= 1'b1; // RULE_12
				end
				if (rst_high_cnt_reg >= STRAP_HOLD_CYC[15:0] - 16'h0001) begin
					strap_mode <= 1'b1; // RULE_21
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Strap outputs
	// ------------------------------------------------------------------
	wire [1:0] fmt_w = sen_decode(sen_lvl_s);
	wire [2:0] pwr_w = pwr_decode(pwr_s);
	always @(posedge clk) begin
		if (!rstn) begin
			low_speed_mode <= 1'b0;
			fmt_offset_binary <= 1'b0;
			out_lvds <= 1'b0;
			pd_global <= 1'b0;
			cha_standby <= 1'b0;
			mux_to_channel_b_output_bus <= 1'b0;
		end else begin
			// Serial pins are straps only while the reset pin is held
			if (strap_mode) begin
				low_speed_mode <= sclk_s; // RULE_01
				fmt_offset_binary <= fmt_w[1]; // RULE_02
				out_lvds <= fmt_w[0]; // RULE_02
			end else begin
				low_speed_mode <= 1'b0;
				fmt_offset_binary <= 1'b0;
				out_lvds <= 1'b0;
			end
			pd_global <= pwr_w[2]; // RULE_03
			cha_standby <= pwr_w[1]; // RULE_03
			mux_to_channel_b_output_bus <= pwr_w[0]; // RULE_04
		end
	end

	// ------------------------------------------------------------------
	// Default restore sweep
	// ------------------------------------------------------------------
	localparam C_CLEAR = 2'b01;
	localparam C_RUN = 2'b10;
	reg [1:0] cstate_reg;
	reg [7:0] clr_addr_reg;
	reg sw_clear_req_reg;
	always @(posedge clk) begin
		if (!rstn) begin
			cstate_reg <= C_CLEAR;
			clr_addr_reg <= 8'h00;
		end else begin
			case (cstate_reg)
			C_CLEAR: begin
				clr_addr_reg <= clr_addr_reg + 8'h01;
				if (clr_addr_reg == 8'hff) begin
					cstate_reg <= C_RUN;
				end
			end
			C_RUN: begin
				if (hw_clear_req_reg || sw_clear_req_reg) begin
					clr_addr_reg <= 8'h00;
					cstate_reg <= C_CLEAR; // RULE_12 RULE_13
				end
			end
			default: cstate_reg <= C_CLEAR;
			endcase
		end
	end
	wire clearing = cstate_reg[0];
	// Pin held high keeps registers at default; requests bridge the gap
	// before the sweep starts so busy never dips between pulse and sweep
	wire hold_default = clearing | rst_pin_s | hw_clear_req_reg |
		sw_clear_req_reg;

	// ------------------------------------------------------------------
	// Serial frame engine
	// ------------------------------------------------------------------
	localparam S_IDLE = 3'b001;
	localparam S_ADDR = 3'b010;
	localparam S_DATA = 3'b100;
	reg [2:0] sstate_reg;
	reg [3:0] bit_cnt_reg;
	reg [14:0] shift_reg;
	reg [7:0] addr_reg;
	reg readout_reg;
	reg rd_en_reg;
	reg rd_wait_reg;
	reg [6:0] rb_shift_reg;
	reg wr_en_reg;
	reg [7:0] wr_addr_reg;
	reg [7:0] wr_data_reg;
	wire [7:0] rd_data;
	wire [15:0] word_w = {shift_reg, serial_data_in_s}; // RULE_23
	wire frame_live = ~sen_n_s & ~hold_default & ~strap_mode; // RULE_05
	wire commit_ok = ~readout_reg |
		(word_w[15:8] == `ACP_CTRL_ADDR); // RULE_15 RULE_18

	always @(posedge clk) begin
		if (!rstn) begin
			sstate_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 15'h0000;
			addr_reg <= 8'h00;
			readout_reg <= 1'b0;
			sw_clear_req_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			sw_clear_req_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			rd_wait_reg <= rd_en_reg;
			wr_en_reg <= 1'b0;
			if (!frame_live) begin
				// Enable high drops any partial word
				sstate_reg <= S_IDLE; // RULE_05 RULE_08
				bit_cnt_reg <= 4'h0;
				shift_reg <= 15'h0000;
			end else begin
				case (sstate_reg)
				S_IDLE: begin
					sstate_reg <= S_ADDR;
				end
				S_ADDR: begin
					if (sclk_fall) begin
						shift_reg <= word_w[14:0]; // RULE_06 RULE_23
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == `ACP_ADDR_LAST_BIT) begin
							addr_reg <= word_w[7:0]; // RULE_10
							rd_en_reg <= readout_reg; // RULE_16
							sstate_reg <= S_DATA;
						end
					end
				end
				S_DATA: begin
					if (sclk_fall) begin
						shift_reg <= word_w[14:0];
						bit_cnt_reg <= bit_cnt_reg + 4'h1; // RULE_09
						if (bit_cnt_reg == `ACP_FRAME_LAST_BIT) begin
							sstate_reg <= S_ADDR; // RULE_09
							shift_reg <= 15'h0000;
							if (commit_ok) begin
								wr_addr_reg <= word_w[15:8]; // RULE_10
								wr_data_reg <= word_w[7:0];
								wr_en_reg <= 1'b1; // RULE_07
							end
						end
					end
				end
				default: sstate_reg <= S_IDLE;
				endcase
			end
			// Control bits live in flops so they act at once
			if (wr_en_reg && wr_addr_reg == `ACP_CTRL_ADDR) begin
				if (wr_data_reg[`ACP_CTRL_SWRESET_BIT]) begin
					sw_clear_req_reg <= 1'b1; // RULE_13
					readout_reg <= 1'b0;
				end else begin
					readout_reg <= wr_data_reg[`ACP_CTRL_READOUT_BIT]; // RULE_22
				end
			end
			// Default restore wins over a control write in the same cycle
			if (hold_default) begin
				readout_reg <= 1'b0; // RULE_12 RULE_13
			end
		end
	end

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	wire mem_we = clearing | (wr_en_reg & (wr_addr_reg != `ACP_CTRL_ADDR));
	acp_regfile #(
		.AW(8),
		.DW(8)
	) u_regs (
		.clk(clk),
		.wr_en(mem_we),
		.wr_addr(clearing ? clr_addr_reg : wr_addr_reg),
		.wr_data(clearing ? `ACP_REG_DEFAULT : wr_data_reg),
		.rd_en(rd_en_reg),
		.rd_addr(addr_reg),
		.rd_data_reg(rd_data)
	);

	// ------------------------------------------------------------------
	// Readback driver
	// ------------------------------------------------------------------
	// Self-clearing reset bit always reads zero
	wire [7:0] rb_byte = (addr_reg == `ACP_CTRL_ADDR) ?
		{7'h00, readout_reg} : rd_data; // RULE_22
	always @(posedge clk) begin
		if (!rstn) begin
			serial_readback_out <= 1'b0;
			serial_readback_oe <= 1'b0;
			rb_shift_reg <= 7'h00;
		end else begin
			// Pin driver is independent of the sample output standard
			serial_readback_oe <= readout_reg; // RULE_19 RULE_20
			if (!frame_live || !readout_reg) begin
				serial_readback_out <= 1'b0;
				rb_shift_reg <= 7'h00;
			end else if (rd_wait_reg) begin
				// Bit 7 ready long before the ninth falling edge
				serial_readback_out <= rb_byte[7]; // RULE_16 RULE_24
				rb_shift_reg <= rb_byte[6:0];
			end else if (sclk_fall && sstate_reg == S_DATA) begin
				if (bit_cnt_reg == `ACP_FRAME_LAST_BIT) begin
					serial_readback_out <= 1'b0;
				end else begin
					// Change after the edge the controller samples on
					serial_readback_out <= rb_shift_reg[6]; // RULE_17 RULE_24
					rb_shift_reg <= {rb_shift_reg[5:0], 1'b0};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Status and write report
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			readout_enabled <= 1'b0;
			reg_clear_busy <= 1'b1;
			cfg_wr_strobe <= 1'b0;
			cfg_wr_addr <= 8'h00;
			cfg_wr_data <= 8'h00;
		end else begin
			readout_enabled <= readout_reg;
			reg_clear_busy <= hold_default;
			cfg_wr_strobe <= wr_en_reg;
			if (wr_en_reg) begin
				cfg_wr_addr <= wr_addr_reg;
				cfg_wr_data <= wr_data_reg;
			end
		end
	end

endmodule // acp_config_port

// ---- sim/acp_ctrl_model.sv ----
// Model of the external controller on the serial configuration pins.
// Assumes clk at 50 ns; the serial clock period is 8 clk (400 ns).
`timescale 1ns/1ps

module acp_ctrl_model (
	input wire clk,
	input wire serial_readback_out,
	output reg serial_clk,
	output reg serial_select_n,
	output reg serial_data_in
);
	reg [7:0] rd_byte;
	integer i;

	// ----
	// Serial link
	// ----
	// Clock idles high and stands still between frames
	initial begin
		serial_clk = 1'b1;
		serial_select_n = 1'b1;
		serial_data_in = 1'b0;
		rd_byte = 8'h00;
	end

	task half;
		repeat (4) @(posedge clk);
	endtask

	task set_sclk(input v);
		@(posedge clk) serial_clk <= v;
	endtask

	// Shift n bits of w, MSB first, in one select-low period
	task xfer(input [47:0] w, input integer n);
		begin
			@(posedge clk);
			serial_select_n <= 1'b0;
			for (i = 0; i < n; i = i + 1) begin
				serial_data_in <= w[47-i];
				half;
				// Value before the fall is the bit being offered
				if (i % 16 >= 8)
					rd_byte = {rd_byte[6:0], serial_readback_out};
				serial_clk <= 1'b0;
				half;
				serial_clk <= 1'b1;
			end
			half;
			serial_select_n <= 1'b1;
			// Released data line must not look like the last bit
			serial_data_in <= ~serial_data_in;
		end
	endtask
endmodule // acp_ctrl_model

// ---- sim/acp_config_port_properties.sv ----
// Port-level checks of the configuration port, bound to acp_config_port.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps

module acp_config_port_properties #(
	parameter STRAP_HOLD_CYC = 20,
	parameter HW_RESET_MIN_CYC = 1
) (
	input wire clk,
	input wire rstn,
	input wire hw_reset_pin,
	input wire serial_clk,
	input wire serial_select_n,
	input wire [1:0] serial_select_level,
	input wire power_strap_1,
	input wire power_strap_2,
	input wire power_strap_3,
	input wire serial_readback_oe,
	input wire strap_mode,
	input wire low_speed_mode,
	input wire fmt_offset_binary,
	input wire out_lvds,
	input wire pd_global,
	input wire cha_standby,
	input wire mux_to_channel_b_output_bus,
	input wire readout_enabled,
	input wire reg_clear_busy,
	input wire cfg_wr_strobe,
	input wire [7:0] cfg_wr_addr,
	input wire [7:0] cfg_wr_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----
	// Helpers
	// ----
	reg [3:0] sel_hi_cnt;
	always @(posedge clk) begin
		if (!rstn || !serial_select_n)
			sel_hi_cnt <= 4'h0;
		else if (sel_hi_cnt != 4'hf)
			sel_hi_cnt <= sel_hi_cnt + 4'h1;
	end
	wire [2:0] pwr = {power_strap_1, power_strap_2, power_strap_3};

	// ----
	// Properties
	// ----
	property p_strobe_one;
		cfg_wr_strobe |=> !cfg_wr_strobe;
	endproperty
	a_strobe_one: assert property (p_strobe_one)
		else $error("write strobe longer than one cycle");
	// Commit latency is short, so a long idle select means a bogus write
	property p_sel_window;
		cfg_wr_strobe |-> sel_hi_cnt < 4'h8;
	endproperty
	a_sel_window: assert property (p_sel_window)
		else $error("write committed with select idle");
	property p_ro_block;
		cfg_wr_strobe && $past(readout_enabled) |-> cfg_wr_addr == 8'h00;
	endproperty
	a_ro_block: assert property (p_ro_block)
		else $error("write passed while readout on");
	property p_swreset;
		cfg_wr_strobe && cfg_wr_addr == 8'h00 && cfg_wr_data[1]
			|-> ##[0:2] (reg_clear_busy && !readout_enabled);
	endproperty
	a_swreset: assert property (p_swreset)
		else $error("soft reset did not start");
	property p_hw_reset;
		$rose(hw_reset_pin) |-> ##[1:5] reg_clear_busy;
	endproperty
	a_hw_reset: assert property (p_hw_reset)
		else $error("reset pin pulse ignored");
	property p_oe_off;
		!readout_enabled [*2] |-> !serial_readback_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("readback driven while disabled");
	property p_pd;
		(pwr == 3'h4) [*5] |-> pd_global && !cha_standby;
	endproperty
	a_pd: assert property (p_pd)
		else $error("power-down decode wrong");
	property p_mux;
		(pwr == 3'h7) [*5] |-> mux_to_channel_b_output_bus && !pd_global;
	endproperty
	a_mux: assert property (p_mux)
		else $error("mux decode wrong");
	property p_low_speed;
		(strap_mode && serial_clk) [*5] |-> low_speed_mode;
	endproperty
	a_low_speed: assert property (p_low_speed)
		else $error("low speed strap ignored");
	property p_fmt;
		(strap_mode && serial_select_level == 2'h2) [*5]
			|-> fmt_offset_binary && out_lvds;
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("format strap decode wrong");

	c_write: cover property (cfg_wr_strobe && cfg_wr_addr != 8'h00);
	c_readback: cover property ($rose(serial_readback_oe));
	c_strap: cover property (strap_mode && out_lvds);
endmodule // acp_config_port_properties

bind acp_config_port acp_config_port_properties #(
	.STRAP_HOLD_CYC(STRAP_HOLD_CYC),
	.HW_RESET_MIN_CYC(HW_RESET_MIN_CYC)
) chk_i (.*);

// ---- sim/acp_config_port_test.sv ----
// Self-checking bench for acp_config_port with a controller model.
// Assumes acp_ctrl_model and the bound checker are compiled first.
`timescale 1ns/1ps

module acp_config_port_test;
	reg clk, rstn, hw_reset_pin;
	reg [1:0] serial_select_level;
	reg power_strap_1, power_strap_2, power_strap_3;
	wire serial_clk, serial_select_n, serial_data_in;
	wire serial_readback_out, serial_readback_oe, strap_mode;
	wire low_speed_mode, fmt_offset_binary, out_lvds, pd_global;
	wire cha_standby, mux_to_channel_b_output_bus, readout_enabled;
	wire reg_clear_busy, cfg_wr_strobe;
	wire [7:0] cfg_wr_addr, cfg_wr_data;
	integer errors, num_checks, wr_cnt, cyc, k, j;
	reg [15:0] last_w;
	reg [2:0] pc;

	acp_config_port #(.STRAP_HOLD_CYC(4), .HW_RESET_MIN_CYC(1)) uut (.*);
	acp_ctrl_model ctl (.*);

	always #25 clk = ~clk;

	// ----
	// Monitor and timeout
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cfg_wr_strobe === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			last_w <= {cfg_wr_addr, cfg_wr_data};
		end
		if (cyc == 20000) begin
			errors = errors + 1;
			give_verdict;
		end
	end

	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask

	task chkb(input got, input exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	task tend(input [63:0] name);
		$display("test %0s done, errors %0d", name, errors);
	endtask

	task give_verdict;
		begin
			$display("checks %0d errors %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask

	// Bounded wait for the default sweep to end
	task wait_idle;
		begin
			k = 0;
			while (reg_clear_busy !== 1'b0 && k < 1000) begin
				@(posedge clk);
				k = k + 1;
			end
			chkb(reg_clear_busy, 1'b0);
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		ctl.xfer({a, d, 32'h0}, 16);
	endtask

	// Readback opens and closes its own readout session
	task rd(input [7:0] a, input [7:0] exp);
		begin
			wr(8'h00, 8'h01);
			ctl.xfer({a, 8'h00, 32'h0}, 16);
			chk({8'h00, ctl.rd_byte}, {8'h00, exp});
			wr(8'h00, 8'h00);
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		hw_reset_pin = 1'b0;
		serial_select_level = 2'h0;
		{power_strap_1, power_strap_2, power_strap_3} = 3'h0;
		errors = 0;
		num_checks = 0;
		wr_cnt = 0;
		cyc = 0;
		last_w = 16'h0000;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wait_idle;
		wr(8'h45, 8'h04);
		chk(last_w, 16'h4504);
		chk(wr_cnt[15:0], 16'h0001);
		tend("write");
		ctl.xfer({16'h29a5, 16'h3d20, 16'hf800}, 37);
		chk(last_w, 16'h3d20);
		chk(wr_cnt[15:0], 16'h0003);
		tend("multi");
		rd(8'h45, 8'h04);
		rd(8'h29, 8'ha5);
		rd(8'h00, 8'h01);
		wr(8'h00, 8'h01);
		chkb(serial_readback_oe, 1'b1);
		chkb(readout_enabled, 1'b1);
		wr(8'h45, 8'h55);
		ctl.xfer({8'h45, 8'h00, 32'h0}, 16);
		chk({8'h00, ctl.rd_byte}, 16'h0004);
		wr(8'h00, 8'h00);
		chkb(serial_readback_oe, 1'b0);
		chkb(readout_enabled, 1'b0);
		tend("readback");
		wr(8'h00, 8'h02);
		wait_idle;
		rd(8'h45, 8'h00);
		tend("swreset");
		wr(8'h29, 8'h77);
		@(posedge clk) hw_reset_pin <= 1'b1;
		@(posedge clk) hw_reset_pin <= 1'b0;
		repeat (4) @(posedge clk);
		chkb(reg_clear_busy, 1'b1);
		wait_idle;
		rd(8'h29, 8'h00);
		tend("hwreset");
		hw_reset_pin <= 1'b1;
		repeat (12) @(posedge clk);
		chkb(strap_mode, 1'b1);
		// Only the documented power codes are applied
		for (j = 0; j < 4; j = j + 1) begin
			pc = {3'h0, 3'h4, 3'h5, 3'h7} >> (9 - 3 * j);
			serial_select_level <= j[1:0];
			{power_strap_1, power_strap_2, power_strap_3} <= pc;
			ctl.set_sclk(j[0]);
			repeat (6) @(posedge clk);
			chk({low_speed_mode, fmt_offset_binary, out_lvds},
				{j[0], j[0] ^ j[1], j[1]});
			chk({pd_global, cha_standby, mux_to_channel_b_output_bus},
				({3'h0, 3'h4, 3'h2, 3'h1} >> (9 - 3 * j)) & 12'h007);
		end
		tend("strap");
		give_verdict;
	end
endmodule // acp_config_port_test
